// ---- shared/pwc_pkg.sv ----
// What this block does
// - accessory key or 30 s after key removal
// - 30 s grace after ignition off
// - no window motion during engine start
// - each switch drives only its window
// - driver panel has four window switches
// - panel hold over 400 ms runs manually
// - door switch hold runs its own window
// - 60 to 400 ms press starts one-touch
// - one-touch runs to end of travel
// - only driver window has one-touch, anti-trap
// - new driver press ends one-touch travel
// - current rise before end means obstacle
// - obstacle while raising reverses to fully open
// - driver press stops reversal, clears jam
package pwc_pkg;

  localparam int unsigned NUM_WIN          = 4;
  // 100 MHz expressed in kHz
  localparam longint unsigned CLK_KHZ      = 64'h186A0;

  // times in milliseconds: 30000, 60, 400, 500
  localparam longint unsigned GRACE_MS     = 64'h7530;
  localparam longint unsigned TAP_MIN_MS   = 64'h3C;
  localparam longint unsigned MANUAL_MS    = 64'h190;
  localparam longint unsigned CRANK_SET_MS = 64'h1F4;

  // cycle counts derived from the clock rate
  localparam logic [31:0] GRACE_CYC        = 32'(GRACE_MS * CLK_KHZ);
  localparam logic [31:0] TAP_MIN_CYC      = 32'(TAP_MIN_MS * CLK_KHZ);
  localparam logic [31:0] MANUAL_CYC       = 32'(MANUAL_MS * CLK_KHZ);
  localparam logic [31:0] CRANK_SET_CYC    = 32'(CRANK_SET_MS * CLK_KHZ);

  // windows with one-touch and anti-trap; bit 0 is the driver window
  localparam logic [3:0]  ONE_TOUCH_MASK   = 4'h1;

  // press direction codes
  localparam logic [1:0]  DIR_NONE         = 2'h0;
  localparam logic [1:0]  DIR_UP           = 2'h1;
  localparam logic [1:0]  DIR_DN           = 2'h2;

  typedef enum logic [5:0] {
    ST_IDLE    = 6'h01,
    ST_MAN_UP  = 6'h02,
    ST_MAN_DN  = 6'h04,
    ST_AUTO_UP = 6'h08,
    ST_AUTO_DN = 6'h10,
    ST_REVERSE = 6'h20
  } pwc_state_t;

endpackage

// ---- shared/pwc_press_if.sv ----
`timescale 1ns/1ps
interface pwc_press_if;
  logic up;
  logic dn;
  logic start;
  logic tap_up;
  logic tap_dn;
  logic man_up;
  logic man_dn;

  modport sw  (output up, output dn, input start, input tap_up, input tap_dn, input man_up, input man_dn);
  modport cls (input up, input dn, output start, output tap_up, output tap_dn, output man_up, output man_dn);
endinterface

// ---- hw/pwc_press.sv ----
`timescale 1ns/1ps
module pwc_press #(
  parameter logic [31:0] TAP_MIN_CYC = pwc_pkg::TAP_MIN_CYC,
  parameter logic [31:0] MANUAL_CYC  = pwc_pkg::MANUAL_CYC
) (
  // clock and reset
  input wire logic   clock,
  input wire logic   reset,
  // switch and its classification
  pwc_press_if.cls   ch
);

  logic [1:0]  dir_ff;
  logic [1:0]  nxt_dir;
  logic [31:0] cnt_ff;
  logic [31:0] nxt_cnt;
  logic        start_ff;
  logic        nxt_start;
  logic [1:0]  tap_ff;
  logic [1:0]  nxt_tap;
  logic [1:0]  cur;

  always_comb begin
    // both directions at once is treated as no press
    cur       = {ch.dn & ~ch.up, ch.up & ~ch.dn};
    nxt_dir   = cur;
    nxt_start = (cur != pwc_pkg::DIR_NONE) && (cur != dir_ff);
    nxt_tap   = pwc_pkg::DIR_NONE;
    if (cur == pwc_pkg::DIR_NONE) begin
      nxt_cnt = 32'h0;
    end else if (cur != dir_ff) begin
      nxt_cnt = 32'h1;
    end else if (cnt_ff <= MANUAL_CYC) begin
      nxt_cnt = cnt_ff + 32'h1;
    end else begin
      nxt_cnt = cnt_ff;
    end
    if ((dir_ff != pwc_pkg::DIR_NONE) && (cur != dir_ff) && (cnt_ff > TAP_MIN_CYC) && (cnt_ff < MANUAL_CYC)) begin
      nxt_tap = dir_ff;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      dir_ff   <= pwc_pkg::DIR_NONE;
      cnt_ff   <= 32'h0;
      start_ff <= 1'b0;
      tap_ff   <= pwc_pkg::DIR_NONE;
    end else begin
      dir_ff   <= nxt_dir;
      cnt_ff   <= nxt_cnt;
      start_ff <= nxt_start;
      tap_ff   <= nxt_tap;
    end
  end

  assign ch.start  = start_ff;
  assign ch.tap_up = tap_ff[0];
  assign ch.tap_dn = tap_ff[1];
  assign ch.man_up = (dir_ff == pwc_pkg::DIR_UP) && (cnt_ff > MANUAL_CYC);
  assign ch.man_dn = (dir_ff == pwc_pkg::DIR_DN) && (cnt_ff > MANUAL_CYC);

endmodule

// ---- hw/pwc_top.sv ----
`timescale 1ns/1ps
module pwc_top #(
  parameter int unsigned NUM_WIN        = pwc_pkg::NUM_WIN,
  parameter logic [31:0] GRACE_CYC      = pwc_pkg::GRACE_CYC,
  parameter logic [31:0] CRANK_SET_CYC  = pwc_pkg::CRANK_SET_CYC,
  parameter logic [31:0] TAP_MIN_CYC    = pwc_pkg::TAP_MIN_CYC,
  parameter logic [31:0] MANUAL_CYC     = pwc_pkg::MANUAL_CYC,
  parameter logic [3:0]  ONE_TOUCH_MASK = pwc_pkg::ONE_TOUCH_MASK
) (
  // clock and reset
  input  wire logic               clock,
  input  wire logic               reset,
  // key and engine state
  input  wire logic               key_acc,
  input  wire logic               ign_on,
  input  wire logic               engine_crank,
  // driver panel, one up/down pair per window
  input  wire logic [NUM_WIN-1:0] drv_up,
  input  wire logic [NUM_WIN-1:0] drv_dn,
  // single door switches, bit 0 unused
  input  wire logic [NUM_WIN-1:0] door_up,
  input  wire logic [NUM_WIN-1:0] door_dn,
  // regulator feedback
  input  wire logic [NUM_WIN-1:0] at_top,
  input  wire logic [NUM_WIN-1:0] at_bottom,
  input  wire logic [NUM_WIN-1:0] current_rise,
  // motor drive and status
  output logic      [NUM_WIN-1:0] motor_up,
  output logic      [NUM_WIN-1:0] motor_dn,
  output logic      [NUM_WIN-1:0] jam,
  output logic                    win_enabled
);

  logic [31:0] grace_ff;
  logic [31:0] nxt_grace;
  logic [31:0] crank_ff;
  logic [31:0] nxt_crank;
  logic        en_ff;
  logic        nxt_en;

  // enable window: key, grace time, engine start lockout
  always_comb begin
    nxt_grace = grace_ff;
    nxt_crank = crank_ff;
    if (key_acc || ign_on) begin
      nxt_grace = GRACE_CYC;
    end else if (grace_ff != 32'h0) begin
      nxt_grace = grace_ff - 32'h1;
    end
    if (engine_crank) begin
      nxt_crank = CRANK_SET_CYC;
    end else if (crank_ff != 32'h0) begin
      nxt_crank = crank_ff - 32'h1;
    end
    nxt_en = (key_acc || ign_on || (grace_ff != 32'h0)) && !engine_crank && (crank_ff == 32'h0);
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      grace_ff <= 32'h0;
      crank_ff <= 32'h0;
      en_ff    <= 1'b0;
    end else begin
      grace_ff <= nxt_grace;
      crank_ff <= nxt_crank;
      en_ff    <= nxt_en;
    end
  end

  assign win_enabled = en_ff;

  pwc_press_if pch [NUM_WIN] ();
  pwc_press_if dch [NUM_WIN] ();

  genvar i;
  generate
    for (i = 0; i < NUM_WIN; i++) begin : g_win
      pwc_pkg::pwc_state_t state_ff;
      pwc_pkg::pwc_state_t nxt_state;
      logic                jam_ff;
      logic                nxt_jam;
      logic                mup_ff;
      logic                nxt_mup;
      logic                mdn_ff;
      logic                nxt_mdn;
      logic                pan_busy;
      logic                man_up;
      logic                man_dn;
      logic                tap_up;
      logic                tap_dn;
      logic                drv_press;
      logic                smart;
      logic                obstacle;
      logic                d_man_up;
      logic                d_man_dn;
      logic                d_tap_up;
      logic                d_tap_dn;

      assign pch[i].up = drv_up[i];
      assign pch[i].dn = drv_dn[i];

      pwc_press #(
        .TAP_MIN_CYC (TAP_MIN_CYC),
        .MANUAL_CYC  (MANUAL_CYC)
      ) u_pan (
        .clock (clock),
        .reset (reset),
        .ch    (pch[i])
      );

      if (i > 0) begin : g_door
        assign dch[i].up = door_up[i];
        assign dch[i].dn = door_dn[i];
        // door switch classified on its own
        pwc_press #(
          .TAP_MIN_CYC (TAP_MIN_CYC),
          .MANUAL_CYC  (MANUAL_CYC)
        ) u_door (
          .clock (clock),
          .reset (reset),
          .ch    (dch[i])
        );
        assign d_man_up = dch[i].man_up;
        assign d_man_dn = dch[i].man_dn;
        assign d_tap_up = dch[i].tap_up;
        assign d_tap_dn = dch[i].tap_dn;
      end else begin : g_nodoor
        // driver window has no separate door switch
        assign dch[i].up = 1'b0;
        assign dch[i].dn = 1'b0;
        assign d_man_up  = 1'b0;
        assign d_man_dn  = 1'b0;
        assign d_tap_up  = 1'b0;
        assign d_tap_dn  = 1'b0;
        // unused channel tied off so nothing in it floats
        assign dch[i].start  = 1'b0;
        assign dch[i].tap_up = 1'b0;
        assign dch[i].tap_dn = 1'b0;
        assign dch[i].man_up = 1'b0;
        assign dch[i].man_dn = 1'b0;
      end

      assign smart     = ONE_TOUCH_MASK[i];
      // panel wins when both switches of a window are used
      assign pan_busy  = drv_up[i] | drv_dn[i];
      assign man_up    = pch[i].man_up | (~pan_busy & d_man_up);
      assign man_dn    = pch[i].man_dn | (~pan_busy & d_man_dn);
      assign tap_up    = smart & (pch[i].tap_up | (~pan_busy & d_tap_up));
      assign tap_dn    = smart & (pch[i].tap_dn | (~pan_busy & d_tap_dn));
      assign drv_press = pch[i].start;
      // current rise short of the top
      assign obstacle  = smart & current_rise[i] & ~at_top[i];

      always_comb begin
        nxt_state = state_ff;
        nxt_jam   = jam_ff;
        case (state_ff)
          pwc_pkg::ST_IDLE: begin
            if (man_up && !at_top[i]) begin
              nxt_state = pwc_pkg::ST_MAN_UP;
            end else if (man_dn && !at_bottom[i]) begin
              nxt_state = pwc_pkg::ST_MAN_DN;
            end else if (tap_up && !at_top[i]) begin
              nxt_state = pwc_pkg::ST_AUTO_UP;
            end else if (tap_dn && !at_bottom[i]) begin
              nxt_state = pwc_pkg::ST_AUTO_DN;
            end
          end
          pwc_pkg::ST_MAN_UP: begin
            if (obstacle) begin
              nxt_state = pwc_pkg::ST_REVERSE;
              nxt_jam   = 1'b1;
            end else if (!man_up || at_top[i]) begin
              nxt_state = pwc_pkg::ST_IDLE;
            end
          end
          pwc_pkg::ST_MAN_DN: begin
            if (!man_dn || at_bottom[i]) begin
              nxt_state = pwc_pkg::ST_IDLE;
            end
          end
          pwc_pkg::ST_AUTO_UP: begin
            if (obstacle) begin
              nxt_state = pwc_pkg::ST_REVERSE;
              nxt_jam   = 1'b1;
            end else if (drv_press || at_top[i]) begin
              nxt_state = pwc_pkg::ST_IDLE;
            end
          end
          pwc_pkg::ST_AUTO_DN: begin
            if (drv_press || at_bottom[i]) begin
              nxt_state = pwc_pkg::ST_IDLE;
            end
          end
          pwc_pkg::ST_REVERSE: begin
            if (drv_press) begin
              nxt_state = pwc_pkg::ST_IDLE;
              nxt_jam   = 1'b0;
            end else if (at_bottom[i]) begin
              nxt_state = pwc_pkg::ST_IDLE;
            end
          end
          default: begin
            nxt_state = pwc_pkg::ST_IDLE;
          end
        endcase
        // nothing moves outside the enable window
        if (!en_ff) begin
          nxt_state = pwc_pkg::ST_IDLE;
        end
        nxt_mup = (nxt_state == pwc_pkg::ST_MAN_UP) || (nxt_state == pwc_pkg::ST_AUTO_UP);
        nxt_mdn = (nxt_state == pwc_pkg::ST_MAN_DN) || (nxt_state == pwc_pkg::ST_AUTO_DN)
                  || (nxt_state == pwc_pkg::ST_REVERSE);
      end

      // motor lines registered from the next state, so no glitch reaches a relay
      always_ff @(posedge clock) begin
        if (reset) begin
          state_ff <= pwc_pkg::ST_IDLE;
          jam_ff   <= 1'b0;
          mup_ff   <= 1'b0;
          mdn_ff   <= 1'b0;
        end else begin
          state_ff <= nxt_state;
          jam_ff   <= nxt_jam;
          mup_ff   <= nxt_mup;
          mdn_ff   <= nxt_mdn;
        end
      end

      assign motor_up[i] = mup_ff;
      assign motor_dn[i] = mdn_ff;
      assign jam[i]      = jam_ff;
    end
  endgenerate

endmodule

// ---- verification/pwc_properties.sv ----
`timescale 1ns/1ps
module pwc_properties #(
  parameter int unsigned NUM_WIN = 4
) (
  // clock and reset
  input wire logic               clock,
  input wire logic               reset,
  // key and engine
  input wire logic               key_acc,
  input wire logic               ign_on,
  input wire logic               engine_crank,
  // switches and feedback
  input wire logic [NUM_WIN-1:0] drv_up,
  input wire logic [NUM_WIN-1:0] drv_dn,
  input wire logic [NUM_WIN-1:0] door_up,
  input wire logic [NUM_WIN-1:0] door_dn,
  input wire logic [NUM_WIN-1:0] at_top,
  input wire logic [NUM_WIN-1:0] at_bottom,
  input wire logic [NUM_WIN-1:0] current_rise,
  // motor drive and status
  input wire logic [NUM_WIN-1:0] motor_up,
  input wire logic [NUM_WIN-1:0] motor_dn,
  input wire logic [NUM_WIN-1:0] jam,
  input wire logic               win_enabled
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  sequence s_obst;
    motor_up[0] && current_rise[0] && !at_top[0];
  endsequence
  sequence s_rev;
    ##2 (motor_dn[0] && jam[0] && !motor_up[0]);
  endsequence
  AST_ENABLE_HOLD: assert property (win_enabled && (key_acc || ign_on) && !engine_crank |=> win_enabled)
    else $error("enable dropped while key present");
  AST_CRANK_OFF: assert property (engine_crank |=> !win_enabled)
    else $error("enabled during engine start");
  AST_IDLE_OFF: assert property (!$past(win_enabled) |-> (motor_up | motor_dn) == 4'h0)
    else $error("motor runs while disabled");
  AST_ONE_DIR: assert property ((motor_up & motor_dn) == 4'h0)
    else $error("both directions driven");
  AST_ISOLATE: assert property ($rose(motor_dn[2]) |-> $past(drv_dn[2] | door_dn[2]))
    else $error("window 2 lowered without its switch");
  AST_LONG_HOLD: assert property ($rose(motor_up[1]) |-> $past(drv_up[1] | door_up[1], 8))
    else $error("plain window raised by short press");
  AST_MAN_RELEASE: assert property ($fell(drv_up[1]) && !door_up[1] |-> ##2 !motor_up[1])
    else $error("manual run outlived release");
  AST_AUTO_END: assert property (motor_up[0] && at_top[0] |-> ##2 !motor_up[0])
    else $error("raise continued past top");
  AST_JAM_REVERSE: assert property (s_obst |-> s_rev)
    else $error("no reversal after obstacle");
  AST_REV_STOP: assert property (jam[0] && motor_dn[0] && $rose(drv_up[0] | drv_dn[0]) |-> ##[1:4] !motor_dn[0])
    else $error("reversal not stopped by press");
endmodule

bind pwc_top pwc_properties #(.NUM_WIN(NUM_WIN)) u_props (.clock, .reset, .key_acc, .ign_on, .engine_crank,
  .drv_up, .drv_dn, .door_up, .door_dn, .at_top, .at_bottom, .current_rise, .motor_up, .motor_dn, .jam, .win_enabled);

// ---- verification/pwc_win_model.sv ----
`timescale 1ns/1ps
module pwc_win_model #(
  parameter int DIV = 2
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       reset,
  // motor drive and forced obstacle
  input  wire logic [3:0] motor_up,
  input  wire logic [3:0] motor_dn,
  input  wire logic [3:0] obst,
  // regulator feedback
  output logic      [3:0] at_top,
  output logic      [3:0] at_bottom,
  output logic      [3:0] current_rise
);
  logic [4:0] pos_ff [4];
  logic [4:0] nxt_pos [4];
  logic [7:0] div_ff;
  logic       step;
  // glass moves once every DIV cycles, a slow regulator
  assign step = div_ff == 8'(DIV - 1);
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      nxt_pos[i] = pos_ff[i];
      if (step && motor_up[i] && pos_ff[i] != 5'h1F) nxt_pos[i] = pos_ff[i] + 5'h01;
      else if (step && motor_dn[i] && pos_ff[i] != 5'h00) nxt_pos[i] = pos_ff[i] - 5'h01;
      at_top[i] = pos_ff[i] == 5'h1F;
      at_bottom[i] = pos_ff[i] == 5'h00;
      current_rise[i] = obst[i] & motor_up[i];
    end
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      pos_ff <= '{default: 5'h10};
      div_ff <= 8'h00;
    end else begin
      pos_ff <= nxt_pos;
      div_ff <= step ? 8'h00 : div_ff + 8'h01;
    end
  end
endmodule

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; $display("mismatch %s exp %h got %h", n, e, g); end end
module tb_top;
  localparam int TAP = 3;
  localparam int MAN = 10;
  localparam int GRACE = 40;
  localparam int CRANK = 10;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic        key_acc = 1'b0;
  logic        ign_on = 1'b0;
  logic        engine_crank = 1'b0;
  logic [15:0] sw = 16'h0000;
  logic [3:0]  obst = 4'h0;
  logic [3:0]  at_top, at_bottom, current_rise, motor_up, motor_dn, jam;
  logic        win_enabled;
  logic        up;
  int          err_count = 0;
  int          cmp_count = 0;
  int          len;
  int          corner[4] = '{3, 4, 9, 10};
  initial forever #5 clock = ~clock;
  pwc_top #(.GRACE_CYC(32'(GRACE)), .CRANK_SET_CYC(32'(CRANK)), .TAP_MIN_CYC(32'(TAP)), .MANUAL_CYC(32'(MAN))) dut (
    .clock, .reset, .key_acc, .ign_on, .engine_crank, .drv_up(sw[3:0]), .drv_dn(sw[7:4]), .door_up(sw[11:8]),
    .door_dn(sw[15:12]), .at_top, .at_bottom, .current_rise, .motor_up, .motor_dn, .jam, .win_enabled);
  pwc_win_model #(.DIV(2)) win (.clock, .reset, .motor_up, .motor_dn, .obst, .at_top, .at_bottom, .current_rise);
  // stimulus lands on the edge by nonblocking assignment; checks see values settled before it
  task automatic cyc(input int k); repeat (k) @(posedge clock); endtask
  task automatic press(input int i, input int k); sw[i] <= 1'b1; cyc(k); sw[i] <= 1'b0; endtask
  task automatic done_test(input string s); $display("test %s done", s); endtask
  function automatic logic [1:0] exp_tap(input int k, input logic u);
    if (k <= TAP || k >= MAN) return 2'h0;
    return u ? 2'h2 : 2'h1;
  endfunction
  task automatic wait_idle();
    int t;
    for (t = 0; t < 300 && (motor_up | motor_dn) !== 4'h0; t++) cyc(1);
    if (t == 300) begin err_count++; $display("mismatch idle exp 0 got busy"); print_verdict(); end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    void'($urandom(10729));
    cyc(6);
    reset <= 1'b0;
    cyc(2);
    press(1, 15);
    cyc(4);
    `CHK("motors", 8'h00, {motor_up, motor_dn})
    key_acc <= 1'b1;
    cyc(3);
    `CHK("win_enabled", 1'b1, win_enabled)
    for (int n = 0; n < 4; n++) begin
      sw[n] <= 1'b1;
      cyc(15);
      `CHK("man_up", 4'h1 << n, motor_up)
      sw[n] <= 1'b0;
      cyc(4);
      `CHK("man_stop", 4'h0, motor_up)
      sw[12 + n] <= 1'b1;
      cyc(15);
      `CHK("door_dn", (n == 0) ? 4'h0 : 4'h1 << n, motor_dn)
      sw[12 + n] <= 1'b0;
      cyc(4);
    end
    done_test("manual");
    // taps on the one-touch window, boundaries first
    for (int n = 0; n < 12; n++) begin
      len = (n < 4) ? corner[n] : 1 + $urandom % MAN;
      up = at_top[0] ? 1'b0 : at_bottom[0] ? 1'b1 : 1'($urandom % 2);
      press(up ? 0 : 4, len);
      cyc(5);
      `CHK("tap", exp_tap(len, up), {motor_up[0], motor_dn[0]})
      wait_idle();
      if (exp_tap(len, up) != 2'h0) `CHK("end", 1'b1, up ? at_top[0] : at_bottom[0])
      cyc(3);
    end
    // plain window ignores a tap
    press(1, 5);
    cyc(5);
    `CHK("plain_tap", 8'h00, {motor_up, motor_dn})
    done_test("tap");
    // motor starts two edges after release, so let it start before waiting
    press(0, 5);
    cyc(5);
    wait_idle();
    press(4, 5);
    cyc(20);
    `CHK("auto_dn", 1'b1, motor_dn[0])
    press(0, 2);
    cyc(4);
    `CHK("auto_exit", 2'h0, {motor_up[0], motor_dn[0]})
    press(0, 5);
    cyc(6);
    obst[0] <= 1'b1;
    cyc(4);
    obst[0] <= 1'b0;
    `CHK("reverse", 3'h6, {jam[0], motor_dn[0], motor_up[0]})
    press(4, 2);
    cyc(5);
    `CHK("rev_stop", 2'h0, {jam[0], motor_dn[0]})
    done_test("anti_trap");
    ign_on <= 1'b1;
    engine_crank <= 1'b1;
    cyc(2);
    `CHK("crank_off", 1'b0, win_enabled)
    press(1, 15);
    cyc(3);
    `CHK("crank_idle", 8'h00, {motor_up, motor_dn})
    engine_crank <= 1'b0;
    cyc(CRANK + 4);
    `CHK("crank_back", 1'b1, win_enabled)
    key_acc <= 1'b0;
    ign_on <= 1'b0;
    cyc(5);
    sw[10] <= 1'b1;
    cyc(15);
    `CHK("grace_run", 4'h4, motor_up)
    sw[10] <= 1'b0;
    cyc(GRACE);
    `CHK("grace_end", 1'b0, win_enabled)
    press(10, 15);
    cyc(3);
    `CHK("grace_idle", 8'h00, {motor_up, motor_dn})
    done_test("enable");
    print_verdict();
  end
endmodule
